// [core/i2c_irq_pkg.sv]
`default_nettype none
package i2c_irq_pkg;
    // register byte addresses on the bus
    localparam logic [11:0] FLAGS_ADDR  = 12'h000;
    localparam logic [11:0] VECTOR_ADDR = 12'h004;
    localparam logic [11:0] ENABLE_ADDR = 12'h008;
    localparam logic [11:0] STATUS_ADDR = 12'h00c;
    localparam logic [11:0] MASK_ADDR   = 12'h010;
    localparam logic [11:0] ADDR_MASK   = 12'hffc;

    localparam int FLAG_W = 16;
    localparam int NUM_SRC = 15;

    // flag bit positions
    localparam int RX0_BIT   = 0;
    localparam int TX0_BIT   = 1;
    localparam int START_BIT = 2;
    localparam int STOP_BIT  = 3;
    localparam int ARB_BIT   = 4;
    localparam int NACK_BIT  = 5;
    localparam int BCNT_BIT  = 6;
    localparam int CLTO_BIT  = 7;
    localparam int RX1_BIT   = 8;
    localparam int TX1_BIT   = 9;
    localparam int RX2_BIT   = 10;
    localparam int TX2_BIT   = 11;
    localparam int RX3_BIT   = 12;
    localparam int TX3_BIT   = 13;
    localparam int BIT9_BIT  = 14;

    localparam logic [15:0] FLAGS_RESET  = 16'h0000;
    localparam logic [15:0] FLAGS_WMASK  = 16'h7fff;
    localparam logic [15:0] VECTOR_RESET = 16'h0000;
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] NO_VECTOR    = 16'h0000;

    // sticky event status bits for the summary interrupt
    localparam int EV_FLAG   = 0;
    localparam int EV_VCLEAR = 1;
    localparam int EV_W      = 2;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

    typedef enum logic [1:0] {
        MODE_IDLE   = 2'b00,
        MODE_MASTER = 2'b01,
        MODE_SLAVE  = 2'b10
    } bus_mode_t;
endpackage
`default_nettype wire

// [core/flag_event_if.sv]
`default_nettype none
interface flag_event_if;
    import i2c_irq_pkg::*;
    logic [FLAG_W-1:0] set_req;
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] enable;
    logic [FLAG_W-1:0] vector;
    modport ctrl (output set_req, output flags, output enable, input vector);
    modport prio (input flags, input enable, output vector);
    modport gate (input  set_req, output flags, output enable, input vector);
endinterface
`default_nettype wire

// [core/flag_set_gate.sv]
`default_nettype none
// decides which engine events may set a flag this cycle
module flag_set_gate
    import i2c_irq_pkg::*;
(
    input  wire logic               mode_master,
    input  wire logic               mode_slave,
    input  wire logic [3:0]         addr_seen,
    input  wire logic [FLAG_W-1:0]  raw_event,
    output logic      [FLAG_W-1:0]  gated
);
    always_comb begin
        gated = raw_event;
        gated[FLAG_W-1] = 1'b0;
        gated[NACK_BIT] = raw_event[NACK_BIT] & mode_master;
        gated[RX0_BIT] = raw_event[RX0_BIT] & (mode_master | (mode_slave & addr_seen[0]));
        gated[TX0_BIT] = raw_event[TX0_BIT] & (mode_master | (mode_slave & addr_seen[0]));
        gated[RX1_BIT] = raw_event[RX1_BIT] & mode_slave & addr_seen[1];
        gated[TX1_BIT] = raw_event[TX1_BIT] & mode_slave & addr_seen[1];
        gated[RX2_BIT] = raw_event[RX2_BIT] & mode_slave & addr_seen[2];
        gated[TX2_BIT] = raw_event[TX2_BIT] & mode_slave & addr_seen[2];
        gated[RX3_BIT] = raw_event[RX3_BIT] & mode_slave & addr_seen[3];
        gated[TX3_BIT] = raw_event[TX3_BIT] & mode_slave & addr_seen[3];
    end
endmodule
`default_nettype wire

// [core/vector_encoder.sv]
`default_nettype none
// priority encoder: lowest code wins
module vector_encoder
    import i2c_irq_pkg::*;
(
    flag_event_if.prio fe
);
    // priority order, highest first
    localparam int ORDER [NUM_SRC] = '{ARB_BIT, NACK_BIT, START_BIT, STOP_BIT,
        RX3_BIT, TX3_BIT, RX2_BIT, TX2_BIT, RX1_BIT, TX1_BIT,
        RX0_BIT, TX0_BIT, BCNT_BIT, CLTO_BIT, BIT9_BIT};

    logic [FLAG_W-1:0] pend;
    always_comb begin
        pend = fe.flags & fe.enable;
        fe.vector = NO_VECTOR;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pend[ORDER[i]]) begin
                fe.vector = 16'((i + 1) * 2);
            end
        end
    end
endmodule
`default_nettype wire

// [core/i2c_irq_flag_vector.sv]
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`default_nettype none
// What this block does
// - nack flag at bit 5, set on received nack, only while master.
// - arbitration-lost flag held at bit 4.
// - stop flag at bit 3, set when stop condition detected.
// - start flag at bit 2, set when start condition detected.
// - tx flag bit 1 on tx empty: master, or slave with address 0 seen.
// - rx flag bit 0 on byte received: master, or slave with address 0 seen.
// - vector is read-only, resets to zero, reads 00h with nothing enabled pending.
// - any write to the vector clears every flag except those an engine event sets in the same cycle.
// - codes 02h arb lost, 04h nack, 06h start, 08h stop, highest first.
// - address 3 at 0Ah/0Ch, address 2 at 0Eh/10h, address 1 at 12h/14h.
// - primary rx 16h, primary tx 18h, below the extra addresses.
// - byte count 1Ah, clock low timeout 1Ch, ninth bit 1Eh lowest.
// - tx flags for addresses 1..3 set only in slave mode after that address.
// - ninth bit at 14, timeout at 7, byte count at 6, bit 15 reads zero.
module i2c_irq_flag_vector
    import i2c_irq_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic                 hsel,
    input  wire logic [11:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic                 hready,
    input  wire logic [31:0]          hwdata,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire i2c_irq_pkg::bus_mode_t bus_mode,
    input  wire logic [3:0]           addr_seen,
    input  wire logic [FLAG_W-1:0]    raw_event,
    output logic [FLAG_W-1:0]         pending_flags,
    output logic                      irq
);
    import i2c_irq_pkg::*;

    typedef struct packed {
        logic              dp_valid;
        logic              dp_write;
        logic [11:0]       dp_addr;
        logic [FLAG_W-1:0] flags;
        logic [FLAG_W-1:0] enable;
        logic [EV_W-1:0]   status;
        logic [EV_W-1:0]   mask;
        logic [31:0]       rdata;
        logic              irq;
    } state_t;

    state_t cur;
    state_t next_cur;

    flag_event_if fe ();
    logic [FLAG_W-1:0] gated;

    flag_set_gate u_gate (
        .mode_master (bus_mode == MODE_MASTER),
        .mode_slave  (bus_mode == MODE_SLAVE),
        .addr_seen   (addr_seen),
        .raw_event   (raw_event),
        .gated       (gated)
    );

    vector_encoder u_enc (
        .fe (fe)
    );

    assign fe.set_req = gated;
    assign fe.flags   = cur.flags;
    assign fe.enable  = cur.enable;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] reg_addr);
        hit = (a & ADDR_MASK) == reg_addr;
    endfunction

    logic addr_take;
    logic wr_flags;
    logic wr_vec;
    logic rd_status;
    logic [FLAG_W-1:0] next_flags;

    always_comb begin
        next_cur = cur;
        next_flags = cur.flags;
        addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);
        wr_flags = cur.dp_valid && cur.dp_write && hit(cur.dp_addr, FLAGS_ADDR);
        wr_vec = cur.dp_valid && cur.dp_write && hit(cur.dp_addr, VECTOR_ADDR);
        rd_status = cur.dp_valid && !cur.dp_write && hit(cur.dp_addr, STATUS_ADDR);

        next_cur.dp_valid = addr_take;
        next_cur.dp_write = hwrite;
        next_cur.dp_addr = haddr;

        if (wr_flags) begin
            next_flags = hwdata[FLAG_W-1:0] & FLAGS_WMASK;
        end
        if (wr_vec) begin
            next_flags = FLAGS_RESET;
        end
        // engine events win over a clear in the same cycle
        next_flags = next_flags | fe.set_req;
        next_cur.flags = next_flags & FLAGS_WMASK;

        if (cur.dp_valid && cur.dp_write && hit(cur.dp_addr, ENABLE_ADDR)) begin
            next_cur.enable = hwdata[FLAG_W-1:0] & FLAGS_WMASK;
        end
        if (cur.dp_valid && cur.dp_write && hit(cur.dp_addr, MASK_ADDR)) begin
            next_cur.mask = hwdata[EV_W-1:0];
        end

        next_cur.status = rd_status ? '0 : cur.status;
        next_cur.status[EV_FLAG] = next_cur.status[EV_FLAG] | (|gated);
        next_cur.status[EV_VCLEAR] = next_cur.status[EV_VCLEAR] | wr_vec;

        next_cur.rdata = 32'h0000_0000;
        if (addr_take && !hwrite) begin
            if (hit(haddr, FLAGS_ADDR)) begin
                next_cur.rdata = {16'h0000, cur.flags};
            end else if (hit(haddr, VECTOR_ADDR)) begin
                next_cur.rdata = {16'h0000, fe.vector};
            end else if (hit(haddr, ENABLE_ADDR)) begin
                next_cur.rdata = {16'h0000, cur.enable};
            end else if (hit(haddr, STATUS_ADDR)) begin
                next_cur.rdata = {30'h0, cur.status};
            end else if (hit(haddr, MASK_ADDR)) begin
                next_cur.rdata = {30'h0, cur.mask};
            end
        end

        next_cur.irq = |(next_cur.status & next_cur.mask);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cur.dp_valid <= 1'b0;
            cur.dp_write <= 1'b0;
            cur.dp_addr <= 12'h000;
            cur.flags <= FLAGS_RESET;
            cur.enable <= ENABLE_RESET;
            cur.status <= 2'h0;
            cur.mask <= 2'h0;
            cur.rdata <= 32'h0000_0000;
            cur.irq <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    assign hrdata = cur.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign pending_flags = cur.flags;
    assign irq = cur.irq;

    nack_master_a: assert property (@(posedge clk) disable iff (srst)
        (bus_mode != MODE_MASTER && !cur.flags[NACK_BIT] && !wr_flags)
        |=> !cur.flags[NACK_BIT]) else $error("nack flag set outside master mode");
    arb_set_a: assert property (@(posedge clk) disable iff (srst)
        raw_event[ARB_BIT] |=> cur.flags[ARB_BIT]) else $error("arb lost not latched");
    stop_set_a: assert property (@(posedge clk) disable iff (srst)
        raw_event[STOP_BIT] |=> cur.flags[STOP_BIT]) else $error("stop not latched");
    start_set_a: assert property (@(posedge clk) disable iff (srst)
        raw_event[START_BIT] |=> cur.flags[START_BIT]) else $error("start not latched");
    tx0_gate_a: assert property (@(posedge clk) disable iff (srst)
        (raw_event[TX0_BIT] && bus_mode == MODE_MASTER) |=> cur.flags[TX0_BIT])
        else $error("tx0 not set in master");
    rx0_gate_a: assert property (@(posedge clk) disable iff (srst)
        (raw_event[RX0_BIT] && bus_mode == MODE_SLAVE && !addr_seen[0] && !cur.flags[RX0_BIT]
         && !wr_flags) |=> !cur.flags[RX0_BIT]) else $error("rx0 set without address match");
    vec_zero_a: assert property (@(posedge clk) disable iff (srst)
        ((cur.flags & cur.enable) == '0) |-> fe.vector == NO_VECTOR)
        else $error("vector nonzero with nothing pending");
    vec_clear_a: assert property (@(posedge clk) disable iff (srst)
        (wr_vec && raw_event == '0) |=> cur.flags == '0) else $error("vector write kept flags");
    arb_top_a: assert property (@(posedge clk) disable iff (srst)
        (cur.flags[ARB_BIT] && cur.enable[ARB_BIT]) |-> fe.vector == 16'h0002)
        else $error("arb lost not top priority");
    bit9_low_a: assert property (@(posedge clk) disable iff (srst)
        ((cur.flags & cur.enable) == 16'h4000) |-> fe.vector == 16'h001e)
        else $error("ninth bit code wrong");
    reserved_zero_a: assert property (@(posedge clk) disable iff (srst)
        !cur.flags[FLAG_W-1]) else $error("reserved bit set");
    tx3_gate_a: assert property (@(posedge clk) disable iff (srst)
        (raw_event[TX3_BIT] && bus_mode == MODE_SLAVE && addr_seen[3]) |=> cur.flags[TX3_BIT])
        else $error("tx3 not set");
    flag_write_a: assert property (@(posedge clk) disable iff (srst)
        (wr_flags && raw_event == '0) |=> cur.flags == ($past(hwdata[FLAG_W-1:0]) & FLAGS_WMASK))
        else $error("flag write not applied");

    logic [FLAG_W-1:0] pend;
    assign pend = cur.flags & cur.enable;

    // each source reports its code when nothing ranked above it is pending
    nack_code_a: assert property (@(posedge clk) disable iff (srst)
        (pend[NACK_BIT] && (pend & 16'h0010) == '0) |-> fe.vector == 16'h0004)
        else $error("nack code wrong");
    start_code_a: assert property (@(posedge clk) disable iff (srst)
        (pend[START_BIT] && (pend & 16'h0030) == '0) |-> fe.vector == 16'h0006)
        else $error("start code wrong");
    stop_code_a: assert property (@(posedge clk) disable iff (srst)
        (pend[STOP_BIT] && (pend & 16'h0034) == '0) |-> fe.vector == 16'h0008)
        else $error("stop code wrong");
    rx3_code_a: assert property (@(posedge clk) disable iff (srst)
        (pend[RX3_BIT] && (pend & 16'h003c) == '0) |-> fe.vector == 16'h000a)
        else $error("rx3 code wrong");
    tx3_code_a: assert property (@(posedge clk) disable iff (srst)
        (pend[TX3_BIT] && (pend & 16'h103c) == '0) |-> fe.vector == 16'h000c)
        else $error("tx3 code wrong");
    rx2_code_a: assert property (@(posedge clk) disable iff (srst)
        (pend[RX2_BIT] && (pend & 16'h303c) == '0) |-> fe.vector == 16'h000e)
        else $error("rx2 code wrong");
    tx2_code_a: assert property (@(posedge clk) disable iff (srst)
        (pend[TX2_BIT] && (pend & 16'h343c) == '0) |-> fe.vector == 16'h0010)
        else $error("tx2 code wrong");
    rx1_code_a: assert property (@(posedge clk) disable iff (srst)
        (pend[RX1_BIT] && (pend & 16'h3c3c) == '0) |-> fe.vector == 16'h0012)
        else $error("rx1 code wrong");
    tx1_code_a: assert property (@(posedge clk) disable iff (srst)
        (pend[TX1_BIT] && (pend & 16'h3d3c) == '0) |-> fe.vector == 16'h0014)
        else $error("tx1 code wrong");
    rx0_code_a: assert property (@(posedge clk) disable iff (srst)
        (pend[RX0_BIT] && (pend & 16'h3f3c) == '0) |-> fe.vector == 16'h0016)
        else $error("rx0 code wrong");
    tx0_code_a: assert property (@(posedge clk) disable iff (srst)
        (pend[TX0_BIT] && (pend & 16'h3f3d) == '0) |-> fe.vector == 16'h0018)
        else $error("tx0 code wrong");
    bcnt_code_a: assert property (@(posedge clk) disable iff (srst)
        (pend[BCNT_BIT] && (pend & 16'h3f3f) == '0) |-> fe.vector == 16'h001a)
        else $error("byte count code wrong");
    clto_code_a: assert property (@(posedge clk) disable iff (srst)
        (pend[CLTO_BIT] && (pend & 16'h3f7f) == '0) |-> fe.vector == 16'h001c)
        else $error("timeout code wrong");

    vec_even_a: assert property (@(posedge clk) disable iff (srst)
        !fe.vector[0] && fe.vector <= 16'h001e)
        else $error("vector code out of range");

    nack_set_a: assert property (@(posedge clk) disable iff (srst)
        (raw_event[NACK_BIT] && bus_mode == MODE_MASTER) |=> cur.flags[NACK_BIT])
        else $error("nack not set in master");
    tx0_slave_a: assert property (@(posedge clk) disable iff (srst)
        (raw_event[TX0_BIT] && bus_mode == MODE_SLAVE && addr_seen[0]) |=> cur.flags[TX0_BIT])
        else $error("tx0 not set in addressed slave");
    tx0_block_a: assert property (@(posedge clk) disable iff (srst)
        (bus_mode == MODE_SLAVE && !addr_seen[0] && !cur.flags[TX0_BIT] && !wr_flags)
        |=> !cur.flags[TX0_BIT]) else $error("tx0 set without address match");
    tx0_idle_a: assert property (@(posedge clk) disable iff (srst)
        (bus_mode == MODE_IDLE && !cur.flags[TX0_BIT] && !wr_flags)
        |=> !cur.flags[TX0_BIT]) else $error("tx0 set while idle");
    rx0_master_a: assert property (@(posedge clk) disable iff (srst)
        (raw_event[RX0_BIT] && bus_mode == MODE_MASTER) |=> cur.flags[RX0_BIT])
        else $error("rx0 not set in master");
    rx0_slave_a: assert property (@(posedge clk) disable iff (srst)
        (raw_event[RX0_BIT] && bus_mode == MODE_SLAVE && addr_seen[0]) |=> cur.flags[RX0_BIT])
        else $error("rx0 not set in addressed slave");
    rx0_idle_a: assert property (@(posedge clk) disable iff (srst)
        (bus_mode == MODE_IDLE && !cur.flags[RX0_BIT] && !wr_flags)
        |=> !cur.flags[RX0_BIT]) else $error("rx0 set while idle");
    tx1_gate_a: assert property (@(posedge clk) disable iff (srst)
        (raw_event[TX1_BIT] && bus_mode == MODE_SLAVE && addr_seen[1]) |=> cur.flags[TX1_BIT])
        else $error("tx1 not set");
    tx2_gate_a: assert property (@(posedge clk) disable iff (srst)
        (raw_event[TX2_BIT] && bus_mode == MODE_SLAVE && addr_seen[2]) |=> cur.flags[TX2_BIT])
        else $error("tx2 not set");
    tx1_addr_a: assert property (@(posedge clk) disable iff (srst)
        (!addr_seen[1] && !cur.flags[TX1_BIT] && !wr_flags)
        |=> !cur.flags[TX1_BIT]) else $error("tx1 set without address match");
    tx_slave_only_a: assert property (@(posedge clk) disable iff (srst)
        (bus_mode != MODE_SLAVE && (cur.flags & 16'h2a00) == '0 && !wr_flags)
        |=> (cur.flags & 16'h2a00) == '0) else $error("extra tx flag set outside slave");
    rx1_gate_a: assert property (@(posedge clk) disable iff (srst)
        (raw_event[RX1_BIT] && bus_mode == MODE_SLAVE && addr_seen[1]) |=> cur.flags[RX1_BIT])
        else $error("rx1 not set");
    rx2_gate_a: assert property (@(posedge clk) disable iff (srst)
        (raw_event[RX2_BIT] && bus_mode == MODE_SLAVE && addr_seen[2]) |=> cur.flags[RX2_BIT])
        else $error("rx2 not set");
    rx3_gate_a: assert property (@(posedge clk) disable iff (srst)
        (raw_event[RX3_BIT] && bus_mode == MODE_SLAVE && addr_seen[3]) |=> cur.flags[RX3_BIT])
        else $error("rx3 not set");
    rx_slave_only_a: assert property (@(posedge clk) disable iff (srst)
        (bus_mode != MODE_SLAVE && (cur.flags & 16'h1500) == '0 && !wr_flags)
        |=> (cur.flags & 16'h1500) == '0) else $error("extra rx flag set outside slave");
    bcnt_set_a: assert property (@(posedge clk) disable iff (srst)
        raw_event[BCNT_BIT] |=> cur.flags[BCNT_BIT]) else $error("byte count not latched");
    clto_set_a: assert property (@(posedge clk) disable iff (srst)
        raw_event[CLTO_BIT] |=> cur.flags[CLTO_BIT]) else $error("timeout not latched");
    bit9_set_a: assert property (@(posedge clk) disable iff (srst)
        raw_event[BIT9_BIT] |=> cur.flags[BIT9_BIT]) else $error("ninth bit not latched");
    arb_hold_a: assert property (@(posedge clk) disable iff (srst)
        (!raw_event[ARB_BIT] && !wr_flags && !cur.flags[ARB_BIT])
        |=> !cur.flags[ARB_BIT]) else $error("arb lost set without event");
    stop_hold_a: assert property (@(posedge clk) disable iff (srst)
        (!raw_event[STOP_BIT] && !wr_flags && !cur.flags[STOP_BIT])
        |=> !cur.flags[STOP_BIT]) else $error("stop set without event");
    start_hold_a: assert property (@(posedge clk) disable iff (srst)
        (!raw_event[START_BIT] && !wr_flags && !cur.flags[START_BIT])
        |=> !cur.flags[START_BIT]) else $error("start set without event");

    vec_ro_a: assert property (@(posedge clk) disable iff (srst)
        wr_vec |=> cur.enable == $past(cur.enable)) else $error("vector write changed enable");
    vec_event_a: assert property (@(posedge clk) disable iff (srst)
        wr_vec |=> (cur.flags & ~$past(gated)) == '0) else $error("vector write left flags");
    flag_event_a: assert property (@(posedge clk) disable iff (srst)
        wr_flags |=> cur.flags == (($past(hwdata[FLAG_W-1:0]) | $past(gated)) & FLAGS_WMASK))
        else $error("flag write with event wrong");
    flag_keep_a: assert property (@(posedge clk) disable iff (srst)
        (!wr_flags && !wr_vec && raw_event == '0) |=> cur.flags == $past(cur.flags))
        else $error("flags changed without cause");
    enable_write_a: assert property (@(posedge clk) disable iff (srst)
        (cur.dp_valid && cur.dp_write && hit(cur.dp_addr, ENABLE_ADDR))
        |=> cur.enable == ($past(hwdata[FLAG_W-1:0]) & FLAGS_WMASK)) else $error("enable lost");
    mask_write_a: assert property (@(posedge clk) disable iff (srst)
        (cur.dp_valid && cur.dp_write && hit(cur.dp_addr, MASK_ADDR))
        |=> cur.mask == $past(hwdata[EV_W-1:0])) else $error("mask write lost");
    status_clear_a: assert property (@(posedge clk) disable iff (srst)
        (rd_status && !(|gated) && !wr_vec) |=> cur.status == '0)
        else $error("status read did not clear");
    event_status_a: assert property (@(posedge clk) disable iff (srst)
        (|gated) |=> cur.status[EV_FLAG]) else $error("event status not set");
    rdata_idle_a: assert property (@(posedge clk) disable iff (srst)
        !(addr_take && !hwrite) |=> hrdata == '0) else $error("read data outside read");
    reset_clear_a: assert property (@(posedge clk)
        srst |=> (cur.flags == FLAGS_RESET && !cur.irq && hrdata == '0))
        else $error("reset left state");
    vec_reset_a: assert property (@(posedge clk)
        srst |=> fe.vector == NO_VECTOR) else $error("vector not zero after reset");

    vec_clear_c: cover property (@(posedge clk) disable iff (srst) wr_vec);
    irq_c: cover property (@(posedge clk) disable iff (srst) cur.irq);
    slave_tx_c: cover property (@(posedge clk) disable iff (srst)
        raw_event[TX1_BIT] && bus_mode == MODE_SLAVE && addr_seen[1]);
    arb_code_c: cover property (@(posedge clk) disable iff (srst) fe.vector == 16'h0002);
    status_read_c: cover property (@(posedge clk) disable iff (srst) rd_status);
endmodule
`default_nettype wire

// [dv/i2c_engine_model.sv]
`default_nettype none
// stands in for the protocol engine: bus mode, address match and event pulses
module i2c_engine_model
    import i2c_irq_pkg::*;
(
    input  wire logic                 clk,
    output var i2c_irq_pkg::bus_mode_t bus_mode,
    output logic [3:0]                addr_seen,
    output logic [FLAG_W-1:0]         raw_event
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        bus_mode  = MODE_IDLE;
        addr_seen = 4'h0;
        raw_event = '0;
    end
    // mode and match are levels; the event is a one-cycle pulse
    task automatic pulse(input bus_mode_t m, input logic [3:0] s, input logic [FLAG_W-1:0] e);
        @(posedge clk);
        bus_mode  <= m;
        addr_seen <= s;
        raw_event <= e;
        @(posedge clk);
        raw_event <= '0;
    endtask
endmodule
`default_nettype wire

// [dv/tb_top.sv]
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import i2c_irq_pkg::*;
    logic              clk = 1'b0;
    logic              srst;
    logic              hsel;
    logic [11:0]       haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic              hready;
    logic [31:0]       hwdata;
    logic [31:0]       hrdata;
    logic              hreadyout;
    logic              hresp;
    bus_mode_t         bus_mode;
    logic [3:0]        addr_seen;
    logic [FLAG_W-1:0] raw_event;
    logic [FLAG_W-1:0] pending_flags;
    logic              irq;
    logic [15:0]       m;
    int                miscompares = 0;
    int                checked = 0;
    int                prio_bit [NUM_SRC] = '{ARB_BIT, NACK_BIT, START_BIT, STOP_BIT, RX3_BIT,
        TX3_BIT, RX2_BIT, TX2_BIT, RX1_BIT, TX1_BIT, RX0_BIT, TX0_BIT, BCNT_BIT, CLTO_BIT, BIT9_BIT};

    always #10 clk = ~clk;
    assign hready = hreadyout;

    i2c_irq_flag_vector dut_u (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bus_mode(bus_mode),
        .addr_seen(addr_seen), .raw_event(raw_event), .pending_flags(pending_flags), .irq(irq));
    i2c_engine_model eng_u (.clk(clk), .bus_mode(bus_mode), .addr_seen(addr_seen),
        .raw_event(raw_event));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1 && n < 100) begin
            n++;
            @(posedge clk);
        end
        if (n == 100) begin
            miscompares++;
        end
    endtask

    // called just after a rising edge; returns at the edge that ends the data phase
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= wr;
        wait_ready;
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready;
        rd = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        ahb(1'b1, a, d, rd);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        ahb(1'b0, a, 32'h0000_0000, rd);
        chk(rd, exp);
    endtask

    // one engine event, flag check, then clear through the vector
    task automatic gate(input bus_mode_t md, input logic [3:0] s, input logic [15:0] ev,
                        input logic [15:0] exp);
        eng_u.pulse(md, s, ev);
        #1;
        chk({16'h0000, pending_flags}, {16'h0000, exp});
        @(posedge clk);
        wr(VECTOR_ADDR, 32'h0000_0000);
        rdchk(FLAGS_ADDR, 32'h0000_0000);
    endtask

    task automatic final_report;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #200us;
        miscompares++;
        final_report;
    end

    initial begin
        srst = 1'b1;
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rdchk(FLAGS_ADDR, {16'h0000, FLAGS_RESET});
        rdchk(VECTOR_ADDR, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(ENABLE_ADDR, 32'h0000_7fff);
        rdchk(VECTOR_ADDR, 32'h0000_0000);
        wr(FLAGS_ADDR, 32'h0000_ffff);
        rdchk(FLAGS_ADDR, 32'h0000_7fff);
        wr(VECTOR_ADDR, 32'h0000_001e);
        rdchk(FLAGS_ADDR, 32'h0000_0000);
        rdchk(VECTOR_ADDR, 32'h0000_0000);
        wr(ENABLE_ADDR, 32'(1 << ARB_BIT));
        wr(FLAGS_ADDR, 32'h0000_7fef);
        rdchk(VECTOR_ADDR, 32'h0000_0000);
        wr(ENABLE_ADDR, 32'h0000_7fff);
        // each source wins over every lower-ranked one set beside it
        for (int k = 0; k < NUM_SRC; k++) begin
            m = 16'h0000;
            for (int j = k; j < NUM_SRC; j++) m[prio_bit[j]] = 1'b1;
            wr(FLAGS_ADDR, {16'h0000, m});
            rdchk(FLAGS_ADDR, {16'h0000, m});
            rdchk(VECTOR_ADDR, 32'((k + 1) * 2));
        end
        wr(VECTOR_ADDR, 32'h0000_0000);
        gate(MODE_SLAVE, 4'hf, 16'h0020, 16'h0000);
        gate(MODE_MASTER, 4'h0, 16'h0020, 16'h0020);
        gate(MODE_SLAVE, 4'he, 16'h0003, 16'h0000);
        gate(MODE_SLAVE, 4'h1, 16'h0003, 16'h0003);
        gate(MODE_MASTER, 4'h0, 16'h0003, 16'h0003);
        gate(MODE_MASTER, 4'he, 16'h2a00, 16'h0000);
        gate(MODE_SLAVE, 4'h2, 16'h2a00, 16'h0200);
        gate(MODE_SLAVE, 4'h8, 16'h2a00, 16'h2000);
        gate(MODE_SLAVE, 4'h0, 16'hc0dc, 16'h40dc);
        // summary interrupt: masked, then unmasked, then cleared by reading status
        wr(MASK_ADDR, 32'h0000_0000);
        rdchk(STATUS_ADDR, 32'h0000_0003);
        eng_u.pulse(MODE_MASTER, 4'h0, 16'h0010);
        repeat (2) @(posedge clk);
        #1 chk({31'h0, irq}, 32'h0000_0000);
        @(posedge clk);
        wr(MASK_ADDR, 32'h0000_0001);
        repeat (2) @(posedge clk);
        #1 chk({31'h0, irq}, 32'h0000_0001);
        @(posedge clk);
        rdchk(STATUS_ADDR, 32'h0000_0001);
        repeat (2) @(posedge clk);
        #1 chk({31'h0, irq}, 32'h0000_0000);
        @(posedge clk);
        rdchk(12'h020, 32'h0000_0000);
        chk({31'h0, hresp}, 32'h0000_0000);
        chk({31'h0, hreadyout}, 32'h0000_0001);
        final_report;
    end
endmodule
`default_nettype wire
